/* File: bench/enable_fault_clear_phase_select_chk.sv */
`timescale 1ns/10ps
// --------------------
// port checker
// --------------------
module enable_fault_clear_phase_select_chk
  import enable_ctrl_pkg::*;
#(
  parameter int unsigned NSRC      = FAULT_SOURCES,
  parameter logic [7:0]  CFG_RESET = CFG_RESET_DEFAULT
) (
  // clock and reset
  input wire logic            clock,
  input wire logic            srst,
  // command port
  input wire logic            cmd_valid,
  input wire logic            cmd_read,
  input wire logic            cmd_send,
  input wire logic [7:0]      cmd_code,
  input wire logic [7:0]      cmd_wdata,
  input wire logic            rsp_reject,
  // alert
  input wire logic            ara_done,
  input wire logic            alert_oe_n,
  // power and run
  input wire logic            power_present,
  input wire logic            uvlo_ok,
  input wire logic            enable_undervoltage_pin,
  input wire logic            run_enable,
  input wire logic            latched_off,
  input wire logic [2:0]      phase_count,
  input wire logic [NSRC-1:0] fault_level,
  // state
  input wire logic            conversion_on,
  input wire logic            ramp_down,
  input wire logic            pin_uvlo_enable,
  input wire logic [7:0]      enable_source_config,
  input wire logic [7:0]      phase_select,
  input wire logic [7:0]      own_phase,
  input wire logic [NSRC+1:0] status_bits
);
  // config fields and decoded conditions
  logic [7:0] cfg;
  logic       pin_active, pin_ctl, uvlo_sel, phase_ok, targeted;
  assign cfg        = enable_source_config;
  assign pin_active = enable_undervoltage_pin == cfg[1];
  assign pin_ctl    = cfg[4] && cfg[2];
  assign uvlo_sel   = cfg[2] && cfg[1];
  assign phase_ok   = cmd_wdata == PHASE_ALL || cmd_wdata < {5'h00, phase_count};
  // raw compare; the target flag lags a cycle
  assign targeted   = phase_select == PHASE_ALL || phase_select == own_phase;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_wr(code);
    cmd_valid && !cmd_read && !cmd_send && cmd_code == code;
  endsequence
  sequence s_clear;
    cmd_valid && cmd_send && cmd_code == CODE_FAULT_CLEAR && targeted;
  endsequence
  // fresh source, nothing to mute or clear it
  sequence s_new_fault;
    fault_level[0] && !status_bits[0] && !ara_done && !cmd_valid ##1 !ara_done && !cmd_valid;
  endsequence

  property p_rsv; cfg[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("config reserved bits set");
  property p_bad_cfg;
    s_wr(CODE_ENABLE_CFG) ##0 cmd_wdata[7:5] != 3'h0
      |=> rsp_reject && status_bits[STATUS_BAD_DATA] && cfg == $past(cfg);
  endproperty
  a_bad_cfg: assert property (p_bad_cfg) else $error("bad config accepted");
  property p_clear;
    s_clear ##0 fault_level == '0 && !ara_done |=> status_bits == '0 ##1 alert_oe_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left status or alert");
  property p_ara;
    ara_done && (fault_level & ~status_bits[NSRC-1:0]) == '0 && !cmd_valid
      |=> status_bits == $past(status_bits) ##1 alert_oe_n;
  endproperty
  a_ara: assert property (p_ara) else $error("alert response mishandled");
  property p_new; s_new_fault |=> !alert_oe_n; endproperty
  a_new: assert property (p_new) else $error("new fault did not alert");
  property p_reset;
    $fell(srst) |-> phase_select == PHASE_RESET && cfg == CFG_RESET && status_bits == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_phase_ok;
    s_wr(CODE_PHASE) ##0 phase_ok |=> phase_select == $past(cmd_wdata) && !rsp_reject;
  endproperty
  a_phase_ok: assert property (p_phase_ok) else $error("phase write lost");
  property p_phase_bad;
    s_wr(CODE_PHASE) ##0 !phase_ok
      |=> rsp_reject && status_bits[STATUS_BAD_DATA] && phase_select == $past(phase_select);
  endproperty
  a_phase_bad: assert property (p_phase_bad) else $error("bad phase accepted");
  property p_pu; !cfg[4] && power_present && uvlo_ok && !latched_off |=> conversion_on; endproperty
  a_pu: assert property (p_pu) else $error("power-up start missing");
  property p_fast_off; conversion_on && pin_ctl && cfg[0] && !pin_active |=> !conversion_on; endproperty
  a_fast_off: assert property (p_fast_off) else $error("immediate stop late");
  property p_hold;
    conversion_on && !ramp_down && pin_ctl && !cfg[0] && !pin_active && (!cfg[3] || run_enable)
      && power_present && uvlo_ok && !latched_off |=> conversion_on;
  endproperty
  a_hold: assert property (p_hold) else $error("soft stop skipped hold");
  property p_run; cfg[4] && cfg[3] && !run_enable |=> !conversion_on; endproperty
  a_run: assert property (p_run) else $error("run bit ignored");
  property p_latch; latched_off |=> !conversion_on; endproperty
  a_latch: assert property (p_latch) else $error("latched unit running");
  property p_uvlo; 1'b1 |=> pin_uvlo_enable == $past(uvlo_sel); endproperty
  a_uvlo: assert property (p_uvlo) else $error("pin lockout enable wrong");
endmodule

bind enable_fault_clear_phase_select enable_fault_clear_phase_select_chk #(
  .NSRC(NSRC), .CFG_RESET(CFG_RESET)
) enable_fault_clear_phase_select_chk_inst (
  .clock, .srst, .cmd_valid, .cmd_read, .cmd_send, .cmd_code, .cmd_wdata, .rsp_reject,
  .ara_done, .alert_oe_n, .power_present, .uvlo_ok, .enable_undervoltage_pin, .run_enable,
  .latched_off, .phase_count, .fault_level, .conversion_on, .ramp_down, .pin_uvlo_enable,
  .enable_source_config, .phase_select, .own_phase, .status_bits
);

/* File: bench/enable_fault_clear_phase_select_tb_top.sv */
`timescale 1ns/10ps
module enable_fault_clear_phase_select_tb_top;
  import enable_ctrl_pkg::*;
  // --------------------
  // stimulus and observed signals
  // --------------------
  localparam int LIMIT = 3000;
  logic        clock = 1'b0, srst = 1'b1, ara_done = 1'b0, latched_off = 1'b0, strap = 1'b0;
  logic        power_present = 1'b1, uvlo_ok = 1'b1, pin = 1'b0, run_enable = 1'b1;
  logic [1:0]  position = 2'h2;
  logic [2:0]  phase_count = 3'h2;
  logic [3:0]  fault_level = 4'h0;
  logic [15:0] hold = 16'h0003, ramp = 16'h0003;
  logic        cmd_valid, cmd_read, cmd_send, rsp_valid, rsp_reject, alert_out, alert_oe_n, rej;
  logic        conversion_on, ramp_down, pin_uvlo_enable, phase_targets_me;
  logic [7:0]  cmd_code, cmd_wdata, rsp_rdata, enable_source_config, phase_select, own_phase;
  logic [7:0]  exp_phase, rd_data;
  logic [5:0]  status_bits;
  logic [7:0]  phase_val [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'hFE, 8'hFF};
  logic [5:0]  phase_bad = 6'h1C;
  int          n_errors = 0, checked = 0, cycles = 0, n;
  wire [7:0]   on8 = {7'h00, conversion_on}, oe8 = {7'h00, alert_oe_n};
  wire [7:0]   st8 = {2'h0, status_bits}, uv8 = {7'h00, pin_uvlo_enable};

  always #25 clock = ~clock;

  host_cmd_model host_cmd_model_inst (
    .clock, .cmd_valid, .cmd_read, .cmd_send, .cmd_code, .cmd_wdata
  );
  enable_fault_clear_phase_select enable_fault_clear_phase_select_inst (
    .clock, .srst, .cmd_valid, .cmd_read, .cmd_send, .cmd_code, .cmd_wdata, .rsp_valid,
    .rsp_reject, .rsp_rdata, .ara_done, .alert_out, .alert_oe_n, .power_present, .uvlo_ok,
    .enable_undervoltage_pin(pin), .run_enable, .latched_off, .hold_cycles(hold),
    .ramp_cycles(ramp), .follower_strap_pin(strap), .phase_position_setting(position),
    .phase_count, .fault_level, .conversion_on, .ramp_down, .pin_uvlo_enable,
    .enable_source_config, .phase_select, .own_phase, .phase_targets_me, .status_bits
  );

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      results();
    end
  end

  // --------------------
  // bus and compare tasks
  // --------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // answer stands one cycle, sampled right after the taking edge
  task automatic xfer(input logic r, input logic s, input logic [7:0] code, input logic [7:0] data);
    host_cmd_model_inst.issue(r, s, code, data);
    rd_data = rsp_rdata;
    rej     = rsp_reject;
    check("rsp_valid", 8'(rsp_valid), 8'h01);
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] data, input logic bad);
    xfer(1'b0, 1'b0, code, data);
    check("rsp_reject", 8'(rej), 8'(bad));
  endtask
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    xfer(1'b1, 1'b0, code, 8'h00);
    check("rsp_rdata", rd_data, exp);
  endtask
  task automatic clr();
    xfer(1'b0, 1'b1, CODE_FAULT_CLEAR, 8'h00);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------
  // test sequence
  // --------------------
  initial begin
    tick(3);
    srst = 1'b0;
    // reset state, then a config value with reserved bits
    rd(CODE_PHASE, PHASE_RESET);
    rd(CODE_ENABLE_CFG, CFG_RESET_DEFAULT);
    check("own_phase", own_phase, PHASE_LEADER);
    wr(CODE_ENABLE_CFG, 8'hE1, 1'b1);
    check("status_bad", st8, 8'h10);
    rd(CODE_ENABLE_CFG, CFG_RESET_DEFAULT);
    // phase values around the supported limit of two
    exp_phase = PHASE_RESET;
    for (int i = 0; i < 6; i++) begin
      wr(CODE_PHASE, phase_val[i], phase_bad[i]);
      if (!phase_bad[i]) exp_phase = phase_val[i];
      rd(CODE_PHASE, exp_phase);
    end
    // clear aimed at another phase leaves status alone
    wr(CODE_PHASE, 8'h01, 1'b0);
    clr();
    check("status_kept", st8, 8'h10);
    check("targets_off", 8'(phase_targets_me), 8'h00);
    wr(CODE_PHASE, PHASE_ALL, 1'b0);
    clr();
    check("status_clear", st8, 8'h00);
    check("targets_on", 8'(phase_targets_me), 8'h01);
    tick(1);
    check("alert_free", oe8, 8'h01);
    // alert raised, answered, muted, then a second source
    fault_level = 4'h1;
    tick(2);
    check("alert_set", oe8, 8'h00);
    check("alert_out", 8'(alert_out), 8'h00);
    ara_done = 1'b1;
    tick(1);
    ara_done = 1'b0;
    tick(1);
    check("alert_ara", oe8, 8'h01);
    check("status_ara", st8, 8'h01);
    tick(3);
    check("alert_muted", oe8, 8'h01);
    fault_level = 4'h3;
    tick(2);
    check("alert_new", oe8, 8'h00);
    fault_level = 4'h1;
    clr();
    check("status_persist", st8, 8'h01);
    tick(1);
    check("alert_again", oe8, 8'h00);
    fault_level = 4'h0;
    clr();
    tick(1);
    check("alert_idle", oe8, 8'h01);
    // active-high pin with immediate stop
    pin = 1'b1;
    tick(2);
    check("on_pin_high", on8, 8'h01);
    check("uvlo_on", uv8, 8'h01);
    pin = 1'b0;
    tick(1);
    check("off_at_once", on8, 8'h00);
    wr(CODE_ENABLE_CFG, 8'h1D, 1'b0);
    tick(2);
    check("on_pin_low", on8, 8'h01);
    check("uvlo_off", uv8, 8'h00);
    // soft stop: hold then ramp
    pin = 1'b1;
    wr(CODE_ENABLE_CFG, 8'h1E, 1'b0);
    tick(2);
    pin = 1'b0;
    for (n = 0; n < 20; n++) begin
      tick(1);
      if (ramp_down) break;
    end
    check("hold_len", n[7:0], hold[7:0] + 8'h01);
    for (n = 1; n < 20; n++) begin
      tick(1);
      if (!ramp_down) break;
    end
    check("ramp_len", n[7:0], ramp[7:0] + 8'h01);
    check("off_after_ramp", on8, 8'h00);
    // run bit, then each source deselected in turn
    pin = 1'b1;
    tick(2);
    run_enable = 1'b0;
    tick(1);
    check("run_off", on8, 8'h00);
    wr(CODE_ENABLE_CFG, 8'h16, 1'b0);
    tick(2);
    check("run_ignored", on8, 8'h01);
    pin = 1'b0;
    run_enable = 1'b1;
    wr(CODE_ENABLE_CFG, 8'h1A, 1'b0);
    tick(2);
    check("pin_ignored", on8, 8'h01);
    check("uvlo_unsel", uv8, 8'h00);
    run_enable = 1'b0;
    wr(CODE_ENABLE_CFG, 8'h00, 1'b0);
    tick(2);
    check("power_up_on", on8, 8'h01);
    // latched off stays off through a clear
    latched_off = 1'b1;
    tick(1);
    check("latched", on8, 8'h00);
    clr();
    tick(2);
    check("no_restart", on8, 8'h00);
    results();
  end
endmodule

/* File: bench/host_cmd_model.sv */
`timescale 1ns/10ps
// --------------------
// bus host model
// --------------------
module host_cmd_model (
  // clock
  input wire logic   clock,
  // command port toward the device, idle at start
  output logic       cmd_valid = 1'b0,
  output logic       cmd_read = 1'b0,
  output logic       cmd_send = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [7:0] cmd_wdata = 8'h00
);
  // one-cycle request; idle bytes inverted
  // send-byte carries no data
  task automatic issue(input logic r, input logic s, input logic [7:0] code, input logic [7:0] data);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_read  = r;
    cmd_send  = s;
    cmd_code  = code;
    cmd_wdata = s ? ~cmd_wdata : data;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~cmd_wdata;
  endtask
endmodule

/* File: design/enable_ctrl_pkg.sv */
package enable_ctrl_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_ENABLE_CFG  = 8'h02;
  localparam logic [7:0] CODE_FAULT_CLEAR = 8'h03;
  localparam logic [7:0] CODE_PHASE       = 8'h04;

  // ----------------------------------------------------------------
  // enable source configuration layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESERVED_MASK = 8'hE0;
  localparam logic [7:0] CFG_RESET_DEFAULT = 8'h1F;
  localparam int unsigned BIT_POWER_UP = 4;
  localparam int unsigned BIT_CMD_SEL  = 3;
  localparam int unsigned BIT_PIN_SEL  = 2;
  localparam int unsigned BIT_POLARITY = 1;
  localparam int unsigned BIT_DELAY    = 0;

  // ----------------------------------------------------------------
  // phase selection
  // ----------------------------------------------------------------
  localparam logic [7:0] PHASE_RESET  = 8'hFF;
  localparam logic [7:0] PHASE_ALL    = 8'hFF;
  localparam logic [7:0] PHASE_LEADER = 8'h00;

  // ----------------------------------------------------------------
  // status layout and widths
  // ----------------------------------------------------------------
  localparam int unsigned FAULT_SOURCES = 4;
  localparam int unsigned STATUS_BAD_DATA = FAULT_SOURCES;
  localparam int unsigned STATUS_BAD_CMD  = FAULT_SOURCES + 1;
  localparam int unsigned STATUS_WIDTH    = FAULT_SOURCES + 2;
  localparam int unsigned TIME_WIDTH      = 16;

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_off, st_on, st_hold, st_ramp} conv_state_type;

endpackage

/* File: design/enable_fault_clear_phase_select.sv */
`timescale 1ns/10ps
// What this block does
// - config bits 7:5 read zero, read-only
// - power-up bit clear: run whenever powered
// - command select clear: ignore run command
// - pin select clear: ignore pin, no UVLO
// - pin select set: pin starts and stops
// - polarity bit: 0 active low, 1 high
// - active-low pin disables pin UVLO function
// - delay clear: pin-off holds, then ramps down
// - delay set: pin-off stops conversion at once
// - enable/undervoltage pin is the control pin
// - bad config value rejected, flagged, alerted
// - send-byte clear empties status of selected phase
// - fault clear releases the alert output
// - fault clear never restarts latched-off unit
// - persisting fault re-sets bit and alerts
// - alert response releases alert, keeps status
// - old sources muted after response, new alert
// - last phase written targets later commands
// - phase resets FFh; FFh and values below phase_count valid
// - unsupported phase rejected, flagged, alerted
// - leader is phase 00h; followers use position
// - run bit enables only under command control
module enable_fault_clear_phase_select
  import enable_ctrl_pkg::*;
#(
  parameter int unsigned      NSRC       = FAULT_SOURCES,
  parameter int unsigned      TW         = TIME_WIDTH,
  parameter logic [7:0]       CFG_RESET  = CFG_RESET_DEFAULT
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            srst,
  // decoded command port
  input  wire logic            cmd_valid,
  input  wire logic            cmd_read,
  input  wire logic            cmd_send,
  input  wire logic [7:0]      cmd_code,
  input  wire logic [7:0]      cmd_wdata,
  output logic                 rsp_valid,
  output logic                 rsp_reject,
  output logic [7:0]           rsp_rdata,
  // alert pin and alert response
  input  wire logic            ara_done,
  output logic                 alert_out,
  output logic                 alert_oe_n,
  // power conditions and run request
  input  wire logic            power_present,
  input  wire logic            uvlo_ok,
  input  wire logic            enable_undervoltage_pin,
  input  wire logic            run_enable,
  input  wire logic            latched_off,
  input  wire logic [TW-1:0]   hold_cycles,
  input  wire logic [TW-1:0]   ramp_cycles,
  // phase straps and configuration
  input  wire logic            follower_strap_pin,
  input  wire logic [1:0]      phase_position_setting,
  input  wire logic [2:0]      phase_count,
  // fault sources
  input  wire logic [NSRC-1:0] fault_level,
  // state outputs
  output logic                 conversion_on,
  output logic                 ramp_down,
  output logic                 pin_uvlo_enable,
  output logic [7:0]           enable_source_config,
  output logic [7:0]           phase_select,
  output logic [7:0]           own_phase,
  output logic                 phase_targets_me,
  output logic [NSRC+1:0]      status_bits
);

  import enable_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  status_link_if #(.WIDTH(NSRC + 2)) link ();

  conv_state_type state;
  conv_state_type next_state;
  logic [TW-1:0]  count;
  logic [TW-1:0]  next_count;

  logic hit_cfg;
  logic hit_clear;
  logic hit_phase;
  logic hit_other;
  logic is_write;
  logic cfg_write;
  logic cfg_bad;
  logic cfg_read;
  logic clear_cmd;
  logic phase_write;
  logic phase_bad;
  logic phase_read;
  logic bad_cmd;
  logic bad_data;
  logic phase_ok_value;
  logic clear_hits_me;
  logic [7:0] next_rdata;
  logic       next_reject;

  logic power_up_behaviour;
  logic cmd_enable_select;
  logic pin_enable_select;
  logic pin_polarity_high;
  logic delay_immediate;
  logic pin_active;
  logic pin_gate;
  logic cmd_gate;
  logic source_on;
  logic supply_ok;
  logic want_on;
  logic pin_caused_off;
  logic [7:0] strap_phase;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // transaction kind and target
  assign is_write  = ~cmd_read & ~cmd_send;
  assign hit_cfg   = cmd_valid & (cmd_code == CODE_ENABLE_CFG);
  assign hit_clear = cmd_valid & (cmd_code == CODE_FAULT_CLEAR);
  assign hit_phase = cmd_valid & (cmd_code == CODE_PHASE);
  assign hit_other = cmd_valid & ~hit_cfg & ~hit_clear & ~hit_phase;

  // config access
  assign cfg_write = hit_cfg & is_write;
  assign cfg_read  = hit_cfg & cmd_read;
  assign cfg_bad   = cfg_write & (|(cmd_wdata & CFG_RESERVED_MASK));

  assign clear_cmd = hit_clear & cmd_send;

  assign phase_ok_value = (cmd_wdata == PHASE_ALL) |
                          (cmd_wdata < {5'h00, phase_count});
  assign phase_write    = hit_phase & is_write;
  assign phase_read     = hit_phase & cmd_read;
  assign phase_bad      = phase_write & ~phase_ok_value;

  // wrong transaction kinds count as unsupported commands
  assign bad_cmd  = hit_other | (hit_cfg & cmd_send) |
                    (hit_clear & ~cmd_send) | (hit_phase & cmd_send);
  assign bad_data = cfg_bad | phase_bad;

  // read data; reserved config bits come back as zero
  assign next_rdata = cfg_read   ? enable_source_config :
                      phase_read ? phase_select : 8'h00;
  assign next_reject = bad_cmd | bad_data;

  // ----------------------------------------------------------------
  // registers written by commands
  // ----------------------------------------------------------------
  // config store; a rejected write leaves the old value
  always_ff @(posedge clock) begin
    if (srst) begin
      enable_source_config <= CFG_RESET & ~CFG_RESERVED_MASK;
    end else if (cfg_write & ~cfg_bad) begin
      enable_source_config <= cmd_wdata & ~CFG_RESERVED_MASK;
    end
  end

  // phase store
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_select <= PHASE_RESET;
    end else if (phase_write & ~phase_bad) begin
      phase_select <= cmd_wdata;
    end
  end

  // response flops, one cycle after the command
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp_valid  <= 1'b0;
      rsp_reject <= 1'b0;
      rsp_rdata  <= 8'h00;
    end else begin
      rsp_valid  <= cmd_valid;
      rsp_reject <= cmd_valid & next_reject;
      rsp_rdata  <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // own phase identity
  // ----------------------------------------------------------------
  // grounded strap means leader
  assign strap_phase = follower_strap_pin ? {6'h00, phase_position_setting}
                                          : PHASE_LEADER;

  // straps are sampled while reset is held, so a moving strap
  // after release cannot change the identity
  always_ff @(posedge clock) begin
    if (srst) begin
      own_phase <= strap_phase;
    end
  end

  assign clear_hits_me = (phase_select == PHASE_ALL) | (phase_select == own_phase);

  // targeting flag for phase-dependent commands elsewhere
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_targets_me <= 1'b1;
    end else begin
      phase_targets_me <= clear_hits_me;
    end
  end

  // ----------------------------------------------------------------
  // status bank and alert
  // ----------------------------------------------------------------
  // invalid data flagged
  assign link.set_level = {bad_cmd, bad_data, fault_level};
  assign link.clear     = clear_cmd & clear_hits_me;
  assign link.ara_done  = ara_done;
  // off-on toggle re-arms muted sources
  assign link.rearm     = (state == st_off) & (next_state == st_on);
  assign status_bits    = link.status;

  fault_status_bank #(.WIDTH(NSRC + 2)) u_bank (
    .clock (clock),
    .srst  (srst),
    .link  (link)
  );

  // open-drain alert: drive low while the bank requests it
  always_ff @(posedge clock) begin
    if (srst) begin
      alert_out  <= 1'b0;
      alert_oe_n <= 1'b1;
    end else begin
      alert_out  <= 1'b0;
      alert_oe_n <= ~link.alert;
    end
  end

  // ----------------------------------------------------------------
  // enable source evaluation
  // ----------------------------------------------------------------
  // config fields
  assign power_up_behaviour = enable_source_config[BIT_POWER_UP];
  assign cmd_enable_select  = enable_source_config[BIT_CMD_SEL];
  assign pin_enable_select  = enable_source_config[BIT_PIN_SEL];
  assign pin_polarity_high  = enable_source_config[BIT_POLARITY];
  assign delay_immediate    = enable_source_config[BIT_DELAY];

  assign pin_active = pin_polarity_high ? enable_undervoltage_pin
                                        : ~enable_undervoltage_pin;
  assign pin_gate = pin_enable_select ? pin_active : 1'b1;
  assign cmd_gate = cmd_enable_select ? run_enable : 1'b1;
  assign source_on = power_up_behaviour ? (cmd_gate & pin_gate) : 1'b1;

  assign supply_ok = power_present & uvlo_ok & ~latched_off;
  assign want_on   = supply_ok & source_on;

  // off caused by the pin alone, with supplies and run still good
  assign pin_caused_off = power_up_behaviour & pin_enable_select & ~pin_active &
                          cmd_gate & supply_ok;

  // pin UVLO usable only for a selected, active-high pin
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_uvlo_enable <= 1'b0;
    end else begin
      pin_uvlo_enable <= pin_enable_select & pin_polarity_high;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // a pin-off during the ramp finishes the ramp; a return of the
  // pin during the hold resumes regulation without a restart
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      st_off: begin
        if (want_on) begin
          next_state = st_on;
        end
      end
      st_on: begin
        if (~want_on) begin
          if (pin_caused_off & ~delay_immediate) begin
            next_state = st_hold;
            next_count = hold_cycles;
          end else begin
            next_state = st_off;
          end
        end
      end
      st_hold: begin
        if (~supply_ok) begin
          next_state = st_off;
        end else if (want_on) begin
          next_state = st_on;
        end else if (count == '0) begin
          next_state = st_ramp;
          next_count = ramp_cycles;
        end else begin
          next_count = count - 1'b1;
        end
      end
      st_ramp: begin
        if (~supply_ok || count == '0) begin
          next_state = st_off;
        end else begin
          next_count = count - 1'b1;
        end
      end
      default: begin
        next_state = st_off;
        next_count = '0;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= st_off;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // registered conversion controls
  always_ff @(posedge clock) begin
    if (srst) begin
      conversion_on <= 1'b0;
      ramp_down     <= 1'b0;
    end else begin
      conversion_on <= (next_state != st_off);
      ramp_down     <= (next_state == st_ramp);
    end
  end

endmodule

/* File: design/fault_status_bank.sv */
`timescale 1ns/10ps
module fault_status_bank #(
  parameter int unsigned WIDTH = 6
) (
  // clock and reset
  input wire logic          clock,
  input wire logic          srst,
  // control side
  status_link_if.bank       link
);
  import enable_ctrl_pkg::*;

  logic [WIDTH-1:0] suppressed;
  logic [WIDTH-1:0] next_status;
  logic [WIDTH-1:0] next_suppressed;
  logic             next_alert;

  // ----------------------------------------------------------------
  // per-bit sticky status and alert suppression
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign next_status[i] = link.set_level[i] | (link.status[i] & ~link.clear);
      // answered bits stay set, only muted
      assign next_suppressed[i] = (link.clear | link.rearm) ? 1'b0 :
                                  link.ara_done ? (suppressed[i] | link.status[i]
                                                   | link.set_level[i]) :
                                  suppressed[i];
      // status flops
      always_ff @(posedge clock) begin
        if (srst) begin
          link.status[i] <= 1'b0;
          suppressed[i]  <= 1'b0;
        end else begin
          link.status[i] <= next_status[i];
          suppressed[i]  <= next_suppressed[i];
        end
      end
    end
  endgenerate

  // alert follows any bit not yet answered
  assign next_alert = |(next_status & ~next_suppressed);

  // alert request flop
  always_ff @(posedge clock) begin
    if (srst) begin
      link.alert <= 1'b0;
    end else begin
      link.alert <= next_alert;
    end
  end

endmodule

/* File: design/status_link_if.sv */
`timescale 1ns/10ps
// status set, clear and alert signals between control and status bank
interface status_link_if #(
  parameter int unsigned WIDTH = 6
);
  logic [WIDTH-1:0] set_level;
  logic             clear;
  logic             ara_done;
  logic             rearm;
  logic [WIDTH-1:0] status;
  logic             alert;

  modport ctrl (output set_level, clear, ara_done, rearm, input status, alert);
  modport bank (input set_level, clear, ara_done, rearm, output status, alert);
endinterface
